// file: shared/tmc_pkg.sv
// Package for the timer module common core: register map, field layouts,
// reset values and prescaler counts.
// Assumes an 8-bit register view placed in the low lane of a 32-bit bus.
package tmc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 10;
	localparam int ADDR_W = 6;
	localparam int NUM_SYNC = 4;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CMPP_LO = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_CMPP_HI = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 6'h28;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pause;
		logic [2:0] clkSel;
		logic timerOn;
		logic [2:0] periodField;
	} tmc_ctrl0_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] pinFn;
		logic initLevel;
		logic polarity;
		logic dutyPeriodSwap;
		logic clearOnA;
	} tmc_ctrl1_t;

	// Bit positions in status and mask
	localparam int INT_A_BIT = 0;
	localparam int INT_P_BIT = 1;
	// Bit positions in pin configuration
	localparam int PIN_ROUTE_BIT = 0;
	localparam int PIN_CAPSRC_BIT = 1;

	// Operating modes
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 10'h000;
	localparam logic [1:0] RST_INT = 2'h0;
	localparam logic [1:0] RST_PIN_CFG = 2'h0;

	// Prescaler terminal counts
	localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
	localparam logic [3:0] HI_DIV16_LAST = 4'hf;
	localparam logic [5:0] HI_DIV64_LAST = 6'h3f;

endpackage : tmc_pkg

// file: rtl/tmc_timer_core.sv
// Timer module common core: 10-bit up counter, comparators A and P,
// capture input, compare/PWM/single pulse output, Avalon-MM slave.
// Assumes clk is the system clock; the high, subsidiary, external clock
// and capture inputs are asynchronous and synchronised here.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps

module tmc_timer_core
	import tmc_pkg::*;
#(
	parameter bit IS_PERIODIC = 1'b0
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic highInternalClock,
	input wire logic subsidiaryClock,
	input wire logic extClockPin,
	input wire logic captureInPin,
	output logic timerOutPin,
	output logic timerOutEnN,
	output logic irq
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [NUM_SYNC-1:0] asyncIn;
	logic [NUM_SYNC-1:0] riseV;
	logic [NUM_SYNC-1:0] fallV;

	assign asyncIn = {captureInPin, extClockPin, subsidiaryClock,
		highInternalClock};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SYNC; gi++)
		begin : gSync
			logic meta;
			logic stable;
			logic last;
			always_ff @(posedge clk)
			begin
				if (!resetn)
				begin
					meta <= 1'b0;
					stable <= 1'b0;
					last <= 1'b0;
				end
				else
				begin
					meta <= asyncIn[gi];
					stable <= meta;
					last <= stable;
				end
			end
			assign riseV[gi] = stable & ~last;
			assign fallV[gi] = ~stable & last;
		end
	endgenerate

	logic hiRise;
	logic subRise;
	logic extRise;
	logic extFall;
	logic capRise;
	logic capFall;
	assign hiRise = riseV[0];
	assign subRise = riseV[1];
	assign extRise = riseV[2];
	assign extFall = fallV[2];
	assign capRise = riseV[3];
	assign capFall = fallV[3];

	// ----------------------------------------------------------------
	// Registers and bus decode
	// ----------------------------------------------------------------
	tmc_ctrl0_t ctrl0;
	tmc_ctrl1_t ctrl1;
	logic [7:0] byteBuffer;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] compareA;
	logic [CNT_W-1:0] compareP;
	logic [1:0] intStatus;
	logic [1:0] intMask;
	logic [1:0] pinCfg;
	logic timerOnPrev;
	logic outLevel;
	logic pulseRun;

	logic busAct;
	logic wrAct;
	logic rdAct;
	logic [7:0] wrByte;
	assign busAct = (read | write) & waitrequest;
	assign wrAct = busAct & write & byteenable[0];
	assign rdAct = busAct & read;
	assign wrByte = writedata[7:0];

	logic timerOnRise;
	assign timerOnRise = ctrl0.timerOn & ~timerOnPrev;

	// ----------------------------------------------------------------
	// Clock selection
	// ----------------------------------------------------------------
	logic [1:0] sysDiv;
	logic [5:0] hiDiv;
	logic selTick;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			sysDiv <= 2'h0;
		else
			sysDiv <= sysDiv + 2'h1;
	end

	// Prescale counts only high clock edges, so its rate is preserved
	always_ff @(posedge clk)
	begin
		if (!resetn)
			hiDiv <= 6'h00;
		else if (hiRise)
			hiDiv <= hiDiv + 6'h01;
	end

	always_comb
	begin
		case (ctrl0.clkSel)
			3'h0: selTick = (sysDiv == SYS_DIV4_LAST);
			3'h1: selTick = 1'b1;
			3'h2: selTick = hiRise & (hiDiv[3:0] == HI_DIV16_LAST);
			3'h3: selTick = hiRise & (hiDiv == HI_DIV64_LAST);
			3'h4: selTick = subRise;
			3'h5: selTick = subRise;
			3'h6: selTick = extRise;
			default: selTick = extFall;
		endcase
	end

	// ----------------------------------------------------------------
	// Comparators
	// ----------------------------------------------------------------
	logic singlePulse;
	logic pwmMode;
	logic countRun;
	logic tick;
	logic [CNT_W-1:0] pTop;
	logic [CNT_W-1:0] pValue;
	logic aHit;
	logic aEnd;
	logic pHit;
	logic clearHit;
	logic [CNT_W-1:0] duty;

	assign pwmMode = (ctrl1.mode == MODE_PWM);
	assign singlePulse = pwmMode & (ctrl1.pinFn == 2'h3);
	assign countRun = ctrl0.timerOn & ~ctrl0.pause & (~singlePulse | pulseRun);
	assign tick = selTick & countRun;

	// top bits compare; field 0 wraps at full count
	assign pValue = IS_PERIODIC ? compareP : {ctrl0.periodField, 7'h00};
	assign pTop = pValue - 10'h001;

	assign aHit = tick & (count == compareA);
	assign aEnd = tick & (count == compareA - 10'h001);
	assign pHit = tick & (count == pTop);

	// swap picks which comparator sets period and which duty
	assign duty = ctrl1.dutyPeriodSwap ? pValue : compareA;

	always_comb
	begin
		if (pwmMode)
			clearHit = ctrl1.dutyPeriodSwap ? aEnd : pHit;
		else if (ctrl1.clearOnA)
			clearHit = aHit;
		else
			clearHit = pHit;
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
			timerOnPrev <= 1'b0;
		else
			timerOnPrev <= ctrl0.timerOn;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			count <= RST_CNT;
		// clear on enable rise, hold when off
		else if (timerOnRise)
			count <= RST_CNT;
		else if (tick)
		begin
			if (clearHit)
				count <= RST_CNT;
			else
				count <= count + 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	logic srcRise;
	logic srcFall;
	logic capEvent;

	// periodic type may take its clock pin as capture source
	assign srcRise = (IS_PERIODIC & pinCfg[PIN_CAPSRC_BIT]) ? extRise : capRise;
	assign srcFall = (IS_PERIODIC & pinCfg[PIN_CAPSRC_BIT]) ? extFall : capFall;

	always_comb
	begin
		capEvent = 1'b0;
		if (ctrl1.mode == MODE_CAPTURE && ctrl0.timerOn)
		begin
			case (ctrl1.pinFn)
				2'h0: capEvent = srcRise;
				2'h1: capEvent = srcFall;
				2'h2: capEvent = srcRise | srcFall;
				default: capEvent = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output waveform
	// ----------------------------------------------------------------
	// pulse armed by external pin edge, ended by comparator A
	always_ff @(posedge clk)
	begin
		if (!resetn)
			pulseRun <= 1'b0;
		else if (timerOnRise | ~singlePulse | ~ctrl0.timerOn)
			pulseRun <= 1'b0;
		else if (aHit)
			pulseRun <= 1'b0;
		else if (extRise)
			pulseRun <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			outLevel <= 1'b0;
		else if (timerOnRise)
			outLevel <= ctrl1.initLevel;
		else if (ctrl1.mode == MODE_COMPARE)
		begin
			if (aHit)
			begin
				case (ctrl1.pinFn)
					2'h0: outLevel <= outLevel;
					2'h1: outLevel <= 1'b0;
					2'h2: outLevel <= 1'b1;
					default: outLevel <= ~outLevel;
				endcase
			end
		end
		else if (pwmMode)
		begin
			case (ctrl1.pinFn)
				2'h0: outLevel <= 1'b0;
				2'h1: outLevel <= 1'b1;
				2'h2: outLevel <= ctrl0.timerOn & (count < duty);
				default: outLevel <= pulseRun;
			endcase
		end
	end

	// Polarity applies to PWM and single pulse only
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			timerOutPin <= 1'b0;
			timerOutEnN <= 1'b1;
		end
		else
		begin
			// pin driven only when routed to timer
			timerOutPin <= pinCfg[PIN_ROUTE_BIT] &
				(outLevel ^ (pwmMode & ctrl1.polarity));
			timerOutEnN <= ~pinCfg[PIN_ROUTE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Control and comparator registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctrl0 <= RST_CTRL;
			ctrl1 <= RST_CTRL;
			intMask <= RST_INT;
			pinCfg <= RST_PIN_CFG;
		end
		else if (wrAct)
		begin
			case (address)
				OFS_CTRL0: ctrl0 <= wrByte;
				OFS_CTRL1: ctrl1 <= wrByte;
				OFS_INT_MASK: intMask <= wrByte[1:0];
				OFS_PIN_CFG: pinCfg <= wrByte[1:0];
				default: ;
			endcase
		end
	end

	// one shared buffer for every low byte
	always_ff @(posedge clk)
	begin
		if (!resetn)
			byteBuffer <= 8'h00;
		else if (wrAct && (address == OFS_CMPA_LO || address == OFS_CMPP_LO))
			// low byte write lands in buffer only
			byteBuffer <= wrByte;
		else if (rdAct)
		begin
			// high byte read latches low byte
			case (address)
				OFS_CNT_HI: byteBuffer <= count[7:0];
				OFS_CMPA_HI: byteBuffer <= compareA[7:0];
				OFS_CMPP_HI: byteBuffer <= IS_PERIODIC ? compareP[7:0] : 8'h00;
				default: ;
			endcase
		end
	end

	// Capture beats a simultaneous bus write to the same register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			compareA <= RST_CNT;
		else if (capEvent)
			compareA <= count;
		// high write transfers buffer to low byte
		else if (wrAct && address == OFS_CMPA_HI)
			compareA <= {wrByte[1:0], byteBuffer};
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			compareP <= RST_CNT;
		else if (IS_PERIODIC && wrAct && address == OFS_CMPP_HI)
			compareP <= {wrByte[1:0], byteBuffer};
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [1:0] intEvent;
	logic [1:0] intClear;

	// one source per comparator; capture reports on A
	assign intEvent[INT_A_BIT] = (ctrl1.mode == MODE_CAPTURE) ? capEvent : aHit;
	assign intEvent[INT_P_BIT] = pHit;
	assign intClear = (wrAct && address == OFS_INT_STAT) ? wrByte[1:0] : 2'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
			intStatus <= RST_INT;
		else
			intStatus <= (intStatus & ~intClear) | intEvent;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |(intStatus & intMask);
	end

	// ----------------------------------------------------------------
	// Read path and wait state
	// ----------------------------------------------------------------
	// One wait state: data is registered at the first edge of a request
	always_ff @(posedge clk)
	begin
		if (!resetn)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~busAct;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			readdata <= 32'h00000000;
		else if (rdAct)
		begin
			case (address)
				OFS_CTRL0: readdata <= {24'h000000, ctrl0};
				OFS_CTRL1: readdata <= {24'h000000, ctrl1};
				// low byte reads return the buffer
				OFS_CNT_LO: readdata <= {24'h000000, byteBuffer};
				OFS_CMPA_LO: readdata <= {24'h000000, byteBuffer};
				OFS_CMPP_LO: readdata <= {24'h000000, byteBuffer};
				OFS_CNT_HI: readdata <= {30'h00000000, count[9:8]};
				OFS_CMPA_HI: readdata <= {30'h00000000, compareA[9:8]};
				OFS_CMPP_HI: readdata <= {30'h00000000, compareP[9:8]};
				OFS_INT_STAT: readdata <= {30'h00000000, intStatus};
				OFS_INT_MASK: readdata <= {30'h00000000, intMask};
				OFS_PIN_CFG: readdata <= {30'h00000000, pinCfg};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

endmodule : tmc_timer_core

// file: bench/tmc_pin_model.sv
// Far-side pin model: two free slow clocks and bench-led pin levels.
// Assumes the bench sets extLevel and capLevel just after a clk edge.
`timescale 1ns/10ps
module tmc_pin_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic extLevel,
	input wire logic capLevel,
	output logic highInternalClock,
	output logic subsidiaryClock,
	output logic extClockPin,
	output logic captureInPin
);
	logic [4:0] div;
	always_ff @(posedge clk)
		div <= resetn ? div + 5'h01 : 5'h00;
	// High clock period 4, subsidiary 32 system cycles
	assign highInternalClock = div[1];
	assign subsidiaryClock = div[4];
	always_ff @(posedge clk)
	begin
		extClockPin <= extLevel;
		captureInPin <= capLevel;
	end
endmodule : tmc_pin_model

// file: bench/tmc_timer_core_chk.sv
// Checker of handshake, pin drive and irq of the timer core.
// Sees only the core's ports; bound at the foot of this file.
`timescale 1ns/10ps
module tmc_timer_core_chk
	import tmc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic timerOutPin,
	input wire logic timerOutEnN,
	input wire logic irq
);
	logic take;
	logic wrTake;
	logic hiRd;
	logic routeOn;
	logic maskOff;
	assign take = (read | write) & waitrequest;
	assign wrTake = take & write & byteenable[0];
	assign hiRd = take & read & (address == OFS_CNT_HI
		| address == OFS_CMPA_HI);
	assign routeOn = wrTake & (address == OFS_PIN_CFG) & writedata[0];
	assign maskOff = wrTake & (address == OFS_INT_MASK)
		& (writedata[1:0] == 2'h0);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	AST_ACK_ONE: assert property (take |=> !waitrequest)
		else $error("request not answered after one cycle");
	AST_ACK_DROP: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for two cycles");
	AST_BYTE_LANE: assert property (readdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	AST_HI_TEN: assert property (hiRd |=> readdata[7:2] == 6'h00)
		else $error("high byte holds more than two bits");
	AST_PIN_IDLE: assert property (timerOutEnN |-> !timerOutPin)
		else $error("pin high while not routed");
	AST_ROUTE_ON: assert property (routeOn |-> ##[1:2] !timerOutEnN)
		else $error("routing did not enable the pin");
	AST_MASK_OFF: assert property (maskOff |-> ##2 !irq)
		else $error("irq high with all sources masked");
	AST_RST_IDLE: assert property (disable iff (1'b0) !resetn |=>
		waitrequest && timerOutEnN && !irq)
		else $error("outputs not idle after reset");
endmodule : tmc_timer_core_chk

bind tmc_timer_core tmc_timer_core_chk u_chk (
	.clk(clk),
	.resetn(resetn),
	.address(address),
	.read(read),
	.write(write),
	.byteenable(byteenable),
	.writedata(writedata),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.timerOutPin(timerOutPin),
	.timerOutEnN(timerOutEnN),
	.irq(irq)
);

// file: bench/tmc_timer_core_tb.sv
// Self-checking bench of the timer core: bus tasks and scenarios.
// Assumes the pin model on the far side and the bound checker.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	bad_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module tmc_timer_core_tb
	import tmc_pkg::*;
;
	logic clk, resetn, read, write, extLevel, capLevel, waitrequest;
	logic timerOutPin, timerOutEnN, irq, highInternalClock;
	logic subsidiaryClock, extClockPin, captureInPin;
	logic [ADDR_W-1:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata;
	int bad_count, check_count;
	tmc_timer_core u_dut (
		.clk(clk),
		.resetn(resetn),
		.address(address),
		.read(read),
		.write(write),
		.byteenable(byteenable),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.highInternalClock(highInternalClock),
		.subsidiaryClock(subsidiaryClock),
		.extClockPin(extClockPin),
		.captureInPin(captureInPin),
		.timerOutPin(timerOutPin),
		.timerOutEnN(timerOutEnN),
		.irq(irq)
	);
	tmc_pin_model u_pins (
		.clk(clk),
		.resetn(resetn),
		.extLevel(extLevel),
		.capLevel(capLevel),
		.highInternalClock(highInternalClock),
		.subsidiaryClock(subsidiaryClock),
		.extClockPin(extClockPin),
		.captureInPin(captureInPin)
	);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// Avalon cycle; ends one edge after release so strobes never double up
	task automatic bus(input logic [ADDR_W-1:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		address <= a;
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 16);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
		if (n >= 16)
		begin
			bad_count++;
			summarize();
		end
	endtask : bus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
		bus(a, 1'b0, 8'h00, q);
	endtask : rd
	task automatic rdCnt(output logic [9:0] c);
		logic [7:0] h, l;
		rd(OFS_CNT_HI, h);
		rd(OFS_CNT_LO, l);
		c = {h[1:0], l};
	endtask : rdCnt
	task automatic runReset();
		logic [ADDR_W-1:0] ofs [4] = '{OFS_CTRL0, OFS_CTRL1, OFS_INT_STAT,
			6'h3c};
		logic [7:0] q;
		foreach (ofs[i])
		begin
			rd(ofs[i], q);
			`CHK("reset value", 8'h00, q)
		end
	endtask : runReset
	task automatic runBuffer();
		logic [7:0] q;
		wr(OFS_CMPA_LO, 8'ha5);
		wr(OFS_CMPA_HI, 8'h02);
		wr(OFS_CMPA_LO, 8'h3c);
		rd(OFS_CMPA_HI, q);
		`CHK("compare a high", 8'h02, q)
		rd(OFS_CMPA_LO, q);
		`CHK("compare a low", 8'ha5, q)
	endtask : runBuffer
	task automatic runClocks();
		int dv [6] = '{4, 1, 64, 256, 32, 32};
		logic [9:0] c, c2;
		int e;
		wr(OFS_CMPA_LO, 8'hff);
		wr(OFS_CMPA_HI, 8'h03);
		wr(OFS_CTRL1, 8'hc1);
		for (int s = 0; s < 6; s++)
		begin
			wr(OFS_CTRL0, {1'b0, 3'(s), 4'h8});
			repeat (512) @(posedge clk);
			wr(OFS_CTRL0, {1'b0, 3'(s), 4'h0});
			rdCnt(c);
			rdCnt(c2);
			e = 512 / dv[s];
			`CHK("rate", 1'b1, c >= e - e / 8 - 2 && c <= e + e / 8 + 4)
			`CHK("residual", c, c2)
		end
	endtask : runClocks
	task automatic runPeriod();
		logic [7:0] q;
		int n;
		wr(OFS_CTRL1, 8'hc0);
		wr(OFS_INT_MASK, 8'h02);
		wr(OFS_CTRL0, 8'h19);
		n = 0;
		while (irq !== 1'b1 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		`CHK("period", 1'b1, n >= 120 && n <= 135)
		if (n >= 300)
			summarize();
		wr(OFS_CTRL0, 8'h10);
		rd(OFS_INT_STAT, q);
		`CHK("status", 8'h02, q)
		wr(OFS_INT_MASK, 8'h00);
		`CHK("irq masked", 1'b0, irq)
		wr(OFS_INT_STAT, 8'h02);
		wr(OFS_INT_MASK, 8'h02);
		`CHK("irq cleared", 1'b0, irq)
	endtask : runPeriod
	task automatic runCapture();
		logic [1:0] ex [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
		logic [7:0] q;
		for (int f = 0; f < 4; f++)
		begin
			wr(OFS_CTRL0, 8'h10);
			wr(OFS_CTRL1, {2'b01, 2'(f), 4'h0});
			wr(OFS_CTRL0, 8'h18);
			wr(OFS_INT_STAT, 8'h03);
			for (int v = 1; v >= 0; v--)
			begin
				capLevel <= 1'(v);
				repeat (8) @(posedge clk);
				rd(OFS_INT_STAT, q);
				`CHK("capture", ex[f][1 - v], q[0])
				wr(OFS_INT_STAT, 8'h03);
			end
		end
	endtask : runCapture
	task automatic runOutput();
		logic [7:0] cf [6] = '{8'h20, 8'h18, 8'h30, 8'h90, 8'h80, 8'ha0};
		logic ex [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		logic [9:0] c;
		wr(OFS_CMPA_LO, 8'h10);
		wr(OFS_CMPA_HI, 8'h00);
		wr(OFS_PIN_CFG, 8'h01);
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_CTRL0, 8'h10);
			wr(OFS_CTRL1, cf[i]);
			wr(OFS_CTRL0, 8'h18);
			repeat (6) @(posedge clk);
			// PWM wave is high while the count is below the duty
			if (i == 5)
				`CHK("pwm high", 1'b1, timerOutPin)
			repeat (34) @(posedge clk);
			`CHK("out pin", ex[i], timerOutPin)
			`CHK("out drive", 1'b0, timerOutEnN)
		end
		// Swap: compare A sets a 16 clock period, P field a 128 duty
		wr(OFS_CTRL0, 8'h10);
		wr(OFS_CTRL1, 8'ha2);
		wr(OFS_CTRL0, 8'h19);
		repeat (40) @(posedge clk);
		`CHK("swap duty", 1'b1, timerOutPin)
		rdCnt(c);
		`CHK("swap period", 1'b1, c < 10'h010)
	endtask : runOutput
	task automatic runExt();
		logic [9:0] c;
		wr(OFS_CTRL0, 8'h10);
		wr(OFS_CTRL1, 8'hc1);
		wr(OFS_CTRL0, 8'h68);
		extLevel <= 1'b1;
		repeat (8) @(posedge clk);
		rdCnt(c);
		`CHK("rise count", 10'h001, c)
		wr(OFS_CTRL0, 8'h70);
		wr(OFS_CTRL0, 8'h78);
		extLevel <= 1'b0;
		repeat (8) @(posedge clk);
		rdCnt(c);
		`CHK("fall count", 10'h001, c)
		wr(OFS_CTRL0, 8'h10);
		wr(OFS_CTRL1, 8'hb0);
		wr(OFS_CTRL0, 8'h18);
		repeat (8) @(posedge clk);
		`CHK("pulse idle", 1'b0, timerOutPin)
		extLevel <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("pulse on", 1'b1, timerOutPin)
		repeat (40) @(posedge clk);
		`CHK("pulse end", 1'b0, timerOutPin)
		wr(OFS_PIN_CFG, 8'h00);
		`CHK("released", 1'b1, timerOutEnN)
	endtask : runExt
	initial
	begin
		resetn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		byteenable = 4'h1;
		writedata = 32'h0;
		extLevel = 1'b0;
		capLevel = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		runReset();
		runBuffer();
		runClocks();
		runPeriod();
		runCapture();
		runOutput();
		runExt();
		summarize();
	end
endmodule : tmc_timer_core_tb
